// >>> rtl/olcb_pkg.sv
package olcb_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [4:0] OLCB_IDX_FRONT_END = 5'h02;
  localparam logic [4:0] OLCB_IDX_RX_PDN = 5'h03;
  localparam logic [4:0] OLCB_IDX_LOSS_STATUS = 5'h04;
  localparam logic [4:0] OLCB_IDX_TX_PDN = 5'h04;
  localparam logic [4:0] OLCB_IDX_BOOST = 5'h07;
  localparam logic [4:0] OLCB_IDX_MONITOR = 5'h0B;
  localparam logic [4:0] OLCB_IDX_LOSS_CRIT = 5'h0D;
  localparam logic [4:0] OLCB_IDX_ALL_ONES = 5'h0E;
  localparam logic [4:0] OLCB_IDX_GLOBAL = 5'h0F;
  localparam logic [4:0] OLCB_IDX_TMPL_PTR = 5'h10;
  localparam logic [4:0] OLCB_IDX_TMPL_SEL = 5'h11;
  localparam logic [4:0] OLCB_IDX_TRISTATE = 5'h12;
  localparam logic [4:0] OLCB_IDX_BANK_PTR = 5'h1F;

  // ****************************************************************
  // Field positions, codes and values after reset.
  // ****************************************************************
  localparam int OLCB_SHORT_PROTECT_BIT = 5;
  localparam int OLCB_MON_TX_BIT = 3;
  localparam logic [7:0] OLCB_BANK_PRIMARY = 8'h00;
  localparam logic [7:0] OLCB_BANK_EXPANDED = 8'hAA;
  localparam logic [7:0] OLCB_RST_BYTE = 8'h00;
  localparam logic [3:0] OLCB_RST_MON = 4'h0;
  localparam logic [2:0] OLCB_RST_PTR = 3'h0;
  localparam logic [2:0] OLCB_RST_TMPL = 3'h0;
  localparam logic [7:0] OLCB_PADDR_HI_MASK = 8'h83;

  typedef enum logic [2:0] {
    OLCB_TMPL_E1,
    OLCB_TMPL_RSV1,
    OLCB_TMPL_RSV2,
    OLCB_TMPL_T1_133,
    OLCB_TMPL_T1_266,
    OLCB_TMPL_T1_399,
    OLCB_TMPL_T1_533,
    OLCB_TMPL_T1_655
  } olcb_tmpl_e;

  // Settings presented to the line front end.
  typedef struct packed {
    logic mon_active;
    logic mon_transmit;
    logic [2:0] mon_channel;
    logic [7:0] loss_etsi;
    logic [7:0] tx_all_ones;
    logic short_protect_en;
    logic [7:0][2:0] tx_template;
    logic [7:0] driver_hiz;
    logic [7:0] front_end_enable;
    logic [7:0] rx_power_down;
    logic [7:0] tx_power_down;
    logic [7:0] receive_boost_enable;
  } olcb_ctl_s;

endpackage

// >>> rtl/olcb_config_bank.sv
`timescale 1ns/10ps
`default_nettype none

module olcb_config_bank
  import olcb_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line side status.
  input wire logic t1_mode,
  input wire logic [7:0] rx_signal_absent,
  input wire logic [7:0] tx_line_clock_pin,
  // Line side control.
  output olcb_ctl_s line_ctl
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [3:0] monitor_channel_code_r;
  logic [7:0] loss_criterion_select_r;
  logic [7:0] auto_all_ones_on_loss_r;
  logic short_protect_off_r;
  logic [2:0] template_channel_pointer_r;
  logic [2:0] line_template_select_r [8];
  logic [7:0] driver_tristate_control_r;
  logic [7:0] bank_pointer_r;
  logic [7:0] front_end_enable_r;
  logic [7:0] receiver_power_down_r;
  logic [7:0] transmitter_power_down_r;
  logic [7:0] receive_boost_enable_r;
  logic [7:0] loss_status_r;
  logic ready_r;
  logic err_r;
  logic [31:0] rdata_r;
  olcb_ctl_s ctl_r;
  olcb_ctl_s ctl_nxt;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  wire logic [4:0] idx = paddr[6:2];
  wire logic aligned = (paddr & OLCB_PADDR_HI_MASK) == 8'h00;
  wire logic exp_sel = bank_pointer_r == OLCB_BANK_EXPANDED;
  wire logic hit_bank = aligned && idx == OLCB_IDX_BANK_PTR;
  wire logic hit_fe = aligned && exp_sel && idx == OLCB_IDX_FRONT_END;
  wire logic hit_rpd = aligned && exp_sel && idx == OLCB_IDX_RX_PDN;
  wire logic hit_tpd = aligned && exp_sel && idx == OLCB_IDX_TX_PDN;
  wire logic hit_bst = aligned && exp_sel && idx == OLCB_IDX_BOOST;
  wire logic pri = aligned && !exp_sel;
  wire logic hit_los = pri && idx == OLCB_IDX_LOSS_STATUS;
  wire logic hit_mon = pri && idx == OLCB_IDX_MONITOR;
  wire logic hit_lac = pri && idx == OLCB_IDX_LOSS_CRIT;
  wire logic hit_ao = pri && idx == OLCB_IDX_ALL_ONES;
  wire logic hit_gcf = pri && idx == OLCB_IDX_GLOBAL;
  wire logic hit_ptr = pri && idx == OLCB_IDX_TMPL_PTR;
  wire logic hit_ts = pri && idx == OLCB_IDX_TMPL_SEL;
  wire logic hit_oe = pri && idx == OLCB_IDX_TRISTATE;
  wire logic hit_any = hit_bank | hit_fe | hit_rpd | hit_tpd | hit_bst |
    hit_los | hit_mon | hit_lac | hit_ao | hit_gcf | hit_ptr | hit_ts |
    hit_oe;

  wire logic setup = psel && !penable;
  wire logic commit = psel && penable && ready_r;
  wire logic wr = commit && pwrite && !err_r;
  wire logic [7:0] wb = pwdata[7:0];
  wire logic [2:0] ptr = template_channel_pointer_r;

  // Read multiplexer; reserved bits read as zero.
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_bank) begin
      rd_byte = bank_pointer_r;
    end else if (hit_fe) begin
      rd_byte = front_end_enable_r;
    end else if (hit_rpd) begin
      rd_byte = receiver_power_down_r;
    end else if (hit_tpd) begin
      rd_byte = transmitter_power_down_r;
    end else if (hit_bst) begin
      rd_byte = receive_boost_enable_r;
    end else if (hit_los) begin
      rd_byte = loss_status_r;
    end else if (hit_mon) begin
      rd_byte = {4'h0, monitor_channel_code_r};
    end else if (hit_lac) begin
      rd_byte = loss_criterion_select_r;
    end else if (hit_ao) begin
      rd_byte = auto_all_ones_on_loss_r;
    end else if (hit_gcf) begin
      rd_byte = {2'h0, short_protect_off_r, 5'h00};
    end else if (hit_ptr) begin
      rd_byte = {5'h00, ptr};
    end else if (hit_ts) begin
      rd_byte = {5'h00, line_template_select_r[ptr]};
    end else if (hit_oe) begin
      rd_byte = driver_tristate_control_r;
    end
  end

  // ****************************************************************
  // APB answer: no wait state, answer registered.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ready_r <= setup;
      err_r <= setup && !hit_any;
      if (setup) begin
        rdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign prdata = rdata_r;
  assign pready = ready_r;
  assign pslverr = err_r;

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_pointer_r <= OLCB_BANK_PRIMARY;
      front_end_enable_r <= OLCB_RST_BYTE;
      receiver_power_down_r <= OLCB_RST_BYTE;
      transmitter_power_down_r <= OLCB_RST_BYTE;
      receive_boost_enable_r <= OLCB_RST_BYTE;
      monitor_channel_code_r <= OLCB_RST_MON;
      loss_criterion_select_r <= OLCB_RST_BYTE;
      auto_all_ones_on_loss_r <= OLCB_RST_BYTE;
      short_protect_off_r <= 1'b0;
      template_channel_pointer_r <= OLCB_RST_PTR;
      driver_tristate_control_r <= OLCB_RST_BYTE;
    end else if (wr) begin
      if (hit_bank) begin
        bank_pointer_r <= wb;
      end
      if (hit_fe) begin
        front_end_enable_r <= wb;
      end
      if (hit_rpd) begin
        receiver_power_down_r <= wb;
      end
      if (hit_tpd) begin
        transmitter_power_down_r <= wb;
      end
      if (hit_bst) begin
        receive_boost_enable_r <= wb;
      end
      if (hit_mon) begin
        monitor_channel_code_r <= wb[3:0];
      end
      if (hit_lac) begin
        loss_criterion_select_r <= wb;
      end
      if (hit_ao) begin
        auto_all_ones_on_loss_r <= wb;
      end
      if (hit_gcf) begin
        short_protect_off_r <= wb[OLCB_SHORT_PROTECT_BIT];
      end
      if (hit_ptr) begin
        template_channel_pointer_r <= wb[2:0];
      end
      if (hit_oe) begin
        driver_tristate_control_r <= wb;
      end
    end
  end

  // The template table is written only through the channel pointer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        line_template_select_r[i] <= OLCB_RST_TMPL;
      end
    end else if (wr && hit_ts) begin
      line_template_select_r[ptr] <= wb[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_status_r <= OLCB_RST_BYTE;
    end else begin
      loss_status_r <= rx_signal_absent;
    end
  end

  // ****************************************************************
  // Line control outputs, bit n for channel n in the per-channel fields.
  // ****************************************************************
  wire logic [7:0] tx_down = transmitter_power_down_r |
    ~tx_line_clock_pin;
  wire logic [3:0] mc = monitor_channel_code_r;

  always_comb begin
    ctl_nxt.mon_active = mc[2:0] != 3'h0;
    ctl_nxt.mon_transmit = mc[OLCB_MON_TX_BIT];
    ctl_nxt.mon_channel = mc[2:0];
    ctl_nxt.loss_etsi = t1_mode ? 8'h00 : loss_criterion_select_r;
    ctl_nxt.tx_all_ones = auto_all_ones_on_loss_r & loss_status_r;
    ctl_nxt.short_protect_en = !short_protect_off_r;
    for (int i = 0; i < 8; i++) begin
      ctl_nxt.tx_template[i] = line_template_select_r[i];
    end
    ctl_nxt.driver_hiz = driver_tristate_control_r | tx_down;
    ctl_nxt.front_end_enable = front_end_enable_r;
    ctl_nxt.rx_power_down = receiver_power_down_r;
    ctl_nxt.tx_power_down = tx_down;
    ctl_nxt.receive_boost_enable = receive_boost_enable_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign line_ctl = ctl_r;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_MON_NONE: assert property (
    monitor_channel_code_r[2:0] == 3'h0 |=> !line_ctl.mon_active)
    else $error("monitor active for a no-monitor code");

  AST_MON_TX: assert property (
    ##1 line_ctl.mon_transmit == $past(monitor_channel_code_r[3]))
    else $error("monitor direction does not follow code bit 3");

  AST_LOSS_T1: assert property (
    t1_mode |=> line_ctl.loss_etsi == 8'h00)
    else $error("E1 criterion applied in T1 mode");

  AST_ALL_ONES: assert property (
    auto_all_ones_on_loss_r[0] && rx_signal_absent[0] &&
    $stable(auto_all_ones_on_loss_r) |-> ##2 line_ctl.tx_all_ones[0])
    else $error("all ones missing during loss on channel 0");

  AST_SHORT: assert property (
    wr && hit_gcf |=> ##1 line_ctl.short_protect_en == !$past(wb[5], 2))
    else $error("short protection does not follow global bit 5");

  AST_TMPL_RD: assert property (
    setup && hit_ts |=> prdata[2:0] == $past(line_template_select_r[ptr]))
    else $error("template read not from pointed channel");

  AST_HIZ: assert property (
    driver_tristate_control_r[7] |=> line_ctl.driver_hiz[7])
    else $error("driver not high impedance");

  AST_BANK: assert property (
    setup && paddr == {1'b0, OLCB_IDX_TX_PDN, 2'b00} &&
    bank_pointer_r == OLCB_BANK_EXPANDED
    |=> !pslverr && prdata[7:0] == $past(transmitter_power_down_r))
    else $error("expanded bank not selected by AAH");

  AST_TX_DOWN: assert property (
    !tx_line_clock_pin[3] |=> line_ctl.tx_power_down[3])
    else $error("low clock pin did not power down transmitter");

  AST_LOS_RD: assert property (
    rx_signal_absent[5] ##1 (setup && hit_los) |=> prdata[5])
    else $error("loss status read as zero while absent");

  AST_ANSWER: assert property (
    setup |=> pready ##1 !pready)
    else $error("answer not exactly one cycle after setup");

  COV_EXP_WR: cover property (wr && hit_fe);
  COV_TS_WR: cover property (wr && hit_ts ##[1:20] setup && hit_ts);
  COV_ERR: cover property (pready && pslverr);
  COV_AO: cover property (line_ctl.tx_all_ones != 8'h00);

endmodule // olcb_config_bank

`default_nettype wire

// >>> verification/olcb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module olcb_host_model
  import olcb_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // APB master.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One APB transfer; the request is held until pready is seen high or 100 cycles pass.
  task automatic xfer(input logic wr, input logic [4:0] idx,
      input logic [7:0] wd, output logic [7:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Enables the front ends; bit 0 stays clear for remote loopback.
  task automatic front_end_on(input logic loopback);
    logic [7:0] rd;
    logic err;
    xfer(1'b1, OLCB_IDX_BANK_PTR, OLCB_BANK_EXPANDED, rd, err);
    xfer(1'b1, OLCB_IDX_FRONT_END, {7'h7F, ~loopback}, rd, err);
  endtask
endmodule // olcb_host_model

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import olcb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, t1_mode;
  logic [7:0] paddr, rx_signal_absent, tx_line_clock_pin, d;
  logic [31:0] pwdata, prdata;
  logic e;
  olcb_ctl_s line_ctl;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;

  olcb_config_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .t1_mode(t1_mode),
    .rx_signal_absent(rx_signal_absent),
    .tx_line_clock_pin(tx_line_clock_pin), .line_ctl(line_ctl));
  olcb_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] v);
    host.xfer(1'b1, i, v, d, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask
  task automatic rd(input logic [4:0] i, input logic [7:0] v, input logic er);
    host.xfer(1'b0, i, 8'h00, d, e);
    chk("read data", {24'h0, v}, {24'h0, d});
    chk("read error", {31'h0, er}, {31'h0, e});
  endtask
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset;
    rd(OLCB_IDX_BANK_PTR, OLCB_BANK_PRIMARY, 1'b0);
    rd(OLCB_IDX_TMPL_PTR, {5'h00, OLCB_RST_PTR}, 1'b0);
    rd(OLCB_IDX_TRISTATE, OLCB_RST_BYTE, 1'b0);
    rd(OLCB_IDX_FRONT_END, 8'h00, 1'b1);
  endtask
  task automatic t_monitor;
    for (int c = 0; c < 16; c++) begin
      wr(OLCB_IDX_MONITOR, 8'(c));
      settle();
      chk("mon active", 32'((c % 8) != 0), 32'(line_ctl.mon_active));
      chk("mon tx", 32'(c / 8), 32'(line_ctl.mon_transmit));
      chk("mon chan", 32'(c % 8), 32'(line_ctl.mon_channel));
    end
  endtask
  task automatic t_loss_crit;
    wr(OLCB_IDX_LOSS_CRIT, 8'hA5);
    settle();
    chk("etsi e1", 32'hA5, 32'(line_ctl.loss_etsi));
    t1_mode <= 1'b1;
    settle();
    chk("etsi t1", 32'h0, 32'(line_ctl.loss_etsi));
    t1_mode <= 1'b0;
  endtask
  task automatic t_all_ones;
    wr(OLCB_IDX_ALL_ONES, 8'h3C);
    rx_signal_absent <= 8'h2F;
    settle();
    chk("all ones", 32'h2C, 32'(line_ctl.tx_all_ones));
    rd(OLCB_IDX_LOSS_STATUS, 8'h2F, 1'b0);
    rx_signal_absent <= 8'h00;
    settle();
    chk("all ones off", 32'h0, 32'(line_ctl.tx_all_ones));
  endtask
  task automatic t_global;
    wr(OLCB_IDX_GLOBAL, 8'h20);
    settle();
    chk("protect off", 32'h0, 32'(line_ctl.short_protect_en));
    rd(OLCB_IDX_GLOBAL, 8'h20, 1'b0);
    wr(OLCB_IDX_GLOBAL, 8'h00);
    settle();
    chk("protect on", 32'h1, 32'(line_ctl.short_protect_en));
  endtask
  task automatic t_template;
    for (int c = 0; c < 8; c++) begin
      wr(OLCB_IDX_TMPL_PTR, 8'(c));
      wr(OLCB_IDX_TMPL_SEL, 8'(7 - c));
    end
    settle();
    for (int c = 0; c < 8; c++) begin
      chk("template", 32'(7 - c), 32'(line_ctl.tx_template[c]));
      wr(OLCB_IDX_TMPL_PTR, 8'(c));
      rd(OLCB_IDX_TMPL_SEL, 8'(7 - c), 1'b0);
    end
  endtask
  task automatic t_expanded;
    wr(OLCB_IDX_TRISTATE, 8'h81);
    host.front_end_on(1'b0);
    wr(OLCB_IDX_RX_PDN, 8'h12);
    wr(OLCB_IDX_TX_PDN, 8'h40);
    wr(OLCB_IDX_BOOST, 8'h5A);
    tx_line_clock_pin <= 8'hFD;
    rd(OLCB_IDX_MONITOR, 8'h00, 1'b1);
    rd(OLCB_IDX_BANK_PTR, OLCB_BANK_EXPANDED, 1'b0);
    rd(OLCB_IDX_TX_PDN, 8'h40, 1'b0);
    settle();
    chk("front end", 32'hFF, 32'(line_ctl.front_end_enable));
    chk("rx pdn", 32'h12, 32'(line_ctl.rx_power_down));
    chk("tx pdn", 32'h42, 32'(line_ctl.tx_power_down));
    chk("hiz", 32'hC3, 32'(line_ctl.driver_hiz));
    chk("boost", 32'h5A, 32'(line_ctl.receive_boost_enable));
    host.front_end_on(1'b1);
    settle();
    chk("front end lb", 32'hFE, 32'(line_ctl.front_end_enable));
    wr(OLCB_IDX_BANK_PTR, OLCB_BANK_PRIMARY);
    rd(OLCB_IDX_FRONT_END, 8'h00, 1'b1);
    rd(OLCB_IDX_LOSS_STATUS, 8'h00, 1'b0);
  endtask

  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Cuts a hung run short after 5000 cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    presetn = 1'b0;
    t1_mode = 1'b0;
    rx_signal_absent = 8'h00;
    tx_line_clock_pin = 8'hFF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_monitor();
    t_loss_crit();
    t_all_ones();
    t_global();
    t_template();
    t_expanded();
    complete_run();
  end
endmodule // testbench

`default_nettype wire
